// File: logic/mfac_defs.svh
// Register offsets, code limits, reset values and timing counts of the moisture filter config bank
`ifndef MFAC_DEFS_SVH
`define MFAC_DEFS_SVH

// ****************************************
// Holding register addresses
// ****************************************
`define MFAC_ADDR_AVG_DELAY 16'h9C5C
`define MFAC_ADDR_SMOOTH 16'h9C5D
`define MFAC_ADDR_RISE 16'h9C5E
`define MFAC_ADDR_FALL 16'h9C5F
`define MFAC_ADDR_DSP 16'h9C60
`define MFAC_ADDR_FILT_FLOOR 16'h9C61
`define MFAC_ADDR_WINDOW 16'h9C62
`define MFAC_ADDR_DEV_LIMIT 16'h9C63
`define MFAC_ADDR_AVG_FLOOR 16'h9C64

// ****************************************
// Highest legal code per register
// ****************************************
`define MFAC_MAX_AVG_DELAY 16'h0007
`define MFAC_MAX_SMOOTH 16'h0063
`define MFAC_MAX_RISE 16'h0032
`define MFAC_MAX_FALL 16'h0033
`define MFAC_MAX_DSP 16'h0005
`define MFAC_MAX_WINDOW 16'h0064
`define MFAC_MAX_MOIST 16'h03E8

// ****************************************
// Reset values
// ****************************************
`define MFAC_RST_AVG_DELAY 16'h0000
`define MFAC_RST_SMOOTH 16'h0000
`define MFAC_RST_RISE 16'h0000
`define MFAC_RST_FALL 16'h0000
`define MFAC_RST_DSP 16'h0000
`define MFAC_RST_FILT_FLOOR 16'h0000
`define MFAC_RST_WINDOW 16'h0000
`define MFAC_RST_DEV_LIMIT 16'h0000
`define MFAC_RST_AVG_FLOOR 16'h0000

// ****************************************
// Slew steps in tenths of a point per sample
// ****************************************
`define MFAC_SLEW_LIGHT 16'h0028
`define MFAC_SLEW_MEDIUM 16'h0014
`define MFAC_SLEW_HEAVY 16'h000A

// ****************************************
// Mode codes and limits
// ****************************************
`define MFAC_PORT_FN_CAL_RANGE 4'h8
`define MFAC_PORT_FN_AVG_HOLD 4'h9
`define MFAC_PORT_FN_STABLE 4'h7
`define MFAC_CAL_MARGIN 16'h001E
`define MFAC_DEV_SCALE 16'h0064

// ****************************************
// Timing: one tenth of a second at the core clock
// ****************************************
`define MFAC_TENTH_NS 100000000
`define MFAC_MCLK_NS 5
`define MFAC_TENTH_CYC (`MFAC_TENTH_NS / `MFAC_MCLK_NS)

`endif

// File: logic/mfac_pkg.sv
// Types shared by the moisture filter config bank
package mfac_pkg;

  typedef enum logic [3:0] {
    AVG_IDLE = 4'b0001,
    AVG_WAIT = 4'b0010,
    AVG_ACC = 4'b0100,
    AVG_HOLD = 4'b1000
  } mfac_avg_e;

  typedef logic [15:0] mfac_word_t;

endpackage

// File: logic/mfac_top.sv
// Moisture filter and averaging configuration bank with its signal path
`timescale 1ns/1ps
`include "mfac_defs.svh"

module mfac_top #(
  parameter int unsigned TENTH_CYC = `MFAC_TENTH_CYC
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_ack,
  output logic reg_exc,
  input wire logic [3:0] second_port_function,
  input wire logic [2:0] alarm_mode,
  input wire logic dig_in,
  input wire logic sample_valid,
  input wire logic [15:0] unscaled_f,
  input wire logic [15:0] unscaled_v,
  input wire logic [15:0] unscaled_e,
  input wire logic [15:0] moisture,
  input wire logic [15:0] avg_include_high,
  input wire logic [15:0] cal_unscaled_low,
  input wire logic [15:0] cal_unscaled_high,
  output logic [15:0] filtered_unscaled,
  output logic [15:0] average_moisture,
  output logic averaging,
  output logic filter_included,
  output logic stable,
  output logic second_digital_port
);

  // ****************************************
  // Holding registers
  // ****************************************
  mfac_pkg::mfac_word_t avg_delay_q, smooth_q, rise_q, fall_q, dsp_q;
  mfac_pkg::mfac_word_t filt_floor_q, window_q, dev_limit_q, avg_floor_q;
  logic hit, legal;

  always_comb begin
    hit = 1'b1;
    legal = 1'b1;
    unique case (reg_addr)
      `MFAC_ADDR_AVG_DELAY: legal = reg_wdata <= `MFAC_MAX_AVG_DELAY;
      `MFAC_ADDR_SMOOTH: legal = reg_wdata <= `MFAC_MAX_SMOOTH;
      `MFAC_ADDR_RISE: legal = reg_wdata <= `MFAC_MAX_RISE;
      `MFAC_ADDR_FALL: legal = reg_wdata <= `MFAC_MAX_FALL;
      `MFAC_ADDR_DSP: legal = reg_wdata <= `MFAC_MAX_DSP;
      `MFAC_ADDR_FILT_FLOOR: legal = 1'b1;
      `MFAC_ADDR_WINDOW: legal = reg_wdata <= `MFAC_MAX_WINDOW;
      `MFAC_ADDR_DEV_LIMIT: legal = 1'b1;
      `MFAC_ADDR_AVG_FLOOR: legal = reg_wdata <= `MFAC_MAX_MOIST;
      default: hit = 1'b0;
    endcase
  end

  wire wr_ok = reg_wr && hit && legal;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      avg_delay_q <= `MFAC_RST_AVG_DELAY;
      smooth_q <= `MFAC_RST_SMOOTH;
      rise_q <= `MFAC_RST_RISE;
      fall_q <= `MFAC_RST_FALL;
      dsp_q <= `MFAC_RST_DSP;
      filt_floor_q <= `MFAC_RST_FILT_FLOOR;
      window_q <= `MFAC_RST_WINDOW;
      dev_limit_q <= `MFAC_RST_DEV_LIMIT;
      avg_floor_q <= `MFAC_RST_AVG_FLOOR;
    end else if (wr_ok) begin
      unique case (reg_addr)
        `MFAC_ADDR_AVG_DELAY: avg_delay_q <= reg_wdata;
        `MFAC_ADDR_SMOOTH: smooth_q <= reg_wdata;
        `MFAC_ADDR_RISE: rise_q <= reg_wdata;
        `MFAC_ADDR_FALL: fall_q <= reg_wdata;
        `MFAC_ADDR_DSP: dsp_q <= reg_wdata;
        `MFAC_ADDR_FILT_FLOOR: filt_floor_q <= reg_wdata;
        `MFAC_ADDR_WINDOW: window_q <= reg_wdata;
        `MFAC_ADDR_DEV_LIMIT: dev_limit_q <= reg_wdata;
        default: avg_floor_q <= reg_wdata;
      endcase
    end
  end

  // ****************************************
  // Register access answer
  // ****************************************
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 16'h0000;
      reg_ack <= 1'b0;
      reg_exc <= 1'b0;
    end else begin
      reg_ack <= reg_wr || reg_rd;
      reg_exc <= (reg_wr || reg_rd) && !(hit && (legal || !reg_wr));
      if (reg_rd && !reg_wr) begin
        unique case (reg_addr)
          `MFAC_ADDR_AVG_DELAY: reg_rdata <= avg_delay_q;
          `MFAC_ADDR_SMOOTH: reg_rdata <= smooth_q;
          `MFAC_ADDR_RISE: reg_rdata <= rise_q;
          `MFAC_ADDR_FALL: reg_rdata <= fall_q;
          `MFAC_ADDR_DSP: reg_rdata <= dsp_q;
          `MFAC_ADDR_FILT_FLOOR: reg_rdata <= filt_floor_q;
          `MFAC_ADDR_WINDOW: reg_rdata <= window_q;
          `MFAC_ADDR_DEV_LIMIT: reg_rdata <= dev_limit_q;
          `MFAC_ADDR_AVG_FLOOR: reg_rdata <= avg_floor_q;
          default: reg_rdata <= 16'h0000;
        endcase
      end
    end
  end

  // ****************************************
  // Decoders
  // ****************************************
  // Filter shift grows with the log of the time in tenths
  function automatic logic [3:0] shift_of(input logic [15:0] tenths);
    logic [3:0] s;
    s = 4'h0;
    for (int i = 0; i < 12; i++) begin
      if (tenths > (16'h0001 << i)) s = 4'(i + 1);
    end
    return s;
  endfunction

  logic [15:0] smooth_tenths, delay_tenths, rise_step, fall_step;
  always_comb begin
    unique case (smooth_q)
      16'h0000: smooth_tenths = 16'h0000;
      16'h0001: smooth_tenths = 16'h000A;
      16'h0002: smooth_tenths = 16'h0019;
      16'h0003: smooth_tenths = 16'h0032;
      16'h0004: smooth_tenths = 16'h004B;
      16'h0005: smooth_tenths = 16'h0064;
      default: smooth_tenths = 16'(smooth_q * 16'h000A);
    endcase
    unique case (avg_delay_q[2:0])
      3'h0: delay_tenths = 16'h0000;
      3'h1: delay_tenths = 16'h0005;
      3'h2: delay_tenths = 16'h000A;
      3'h3: delay_tenths = 16'h000F;
      3'h4: delay_tenths = 16'h0014;
      3'h5: delay_tenths = 16'h0032;
      3'h6: delay_tenths = 16'h0064;
      3'h7: delay_tenths = 16'h00C8;
    endcase
    rise_step = (rise_q == 16'h0001) ? `MFAC_SLEW_LIGHT : (rise_q == 16'h0002) ? `MFAC_SLEW_MEDIUM :
                (rise_q == 16'h0003) ? `MFAC_SLEW_HEAVY : rise_q;
    fall_step = (fall_q == 16'h0001) ? `MFAC_SLEW_LIGHT : (fall_q == 16'h0002) ? `MFAC_SLEW_MEDIUM :
                (fall_q == 16'h0003) ? `MFAC_SLEW_HEAVY : fall_q;
  end

  // Measurement chosen by alarm mode; legacy and unknown use F
  logic [15:0] sel;
  always_comb begin
    unique case (alarm_mode)
      3'h2: sel = unscaled_v;
      3'h3: sel = unscaled_e;
      default: sel = unscaled_f;
    endcase
  end

  // ****************************************
  // Filter chain: smoothing, slew limit, signal filter
  // ****************************************
  logic [15:0] smooth_out_q, slew_out_q;
  wire include_now = sel >= filt_floor_q;
  wire logic signed [16:0] d_smooth = $signed({1'b0, sel}) - $signed({1'b0, smooth_out_q});
  wire logic signed [16:0] d_slew = $signed({1'b0, smooth_out_q}) - $signed({1'b0, slew_out_q});
  wire logic signed [16:0] d_dsp = $signed({1'b0, slew_out_q}) - $signed({1'b0, filtered_unscaled});
  wire logic signed [16:0] st_smooth = d_smooth >>> shift_of(smooth_tenths);
  wire logic signed [16:0] st_dsp = d_dsp >>> dsp_q[2:0];
  logic signed [16:0] st_slew;

  always_comb begin
    st_slew = d_slew;
    if (rise_q != 16'h0000 && d_slew > $signed({1'b0, rise_step})) st_slew = $signed({1'b0, rise_step});
    if (fall_q != 16'h0000 && d_slew < -$signed({1'b0, fall_step})) st_slew = -$signed({1'b0, fall_step});
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      smooth_out_q <= 16'h0000;
      slew_out_q <= 16'h0000;
      filtered_unscaled <= 16'h0000;
      filter_included <= 1'b0;
    end else if (sample_valid) begin
      filter_included <= include_now;
      if (include_now) begin
        smooth_out_q <= 16'(smooth_out_q + st_smooth[15:0]);
        slew_out_q <= 16'(slew_out_q + st_slew[15:0]);
        filtered_unscaled <= 16'(filtered_unscaled + st_dsp[15:0]);
      end
    end
  end

  // ****************************************
  // Stability tracker
  // ****************************************
  logic [15:0] track_q;
  wire logic signed [16:0] d_track = $signed({1'b0, sel}) - $signed({1'b0, track_q});
  wire logic signed [16:0] st_track = d_track >>> shift_of(16'(window_q * 16'h000A));
  wire logic [15:0] dev_abs = d_track[16] ? 16'(-d_track) : d_track[15:0];
  wire logic [31:0] dev_milli = dev_abs * `MFAC_DEV_SCALE;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      track_q <= 16'h0000;
      stable <= 1'b0;
    end else if (sample_valid) begin
      track_q <= 16'(track_q + st_track[15:0]);
      stable <= dev_milli < {16'h0000, dev_limit_q};
    end
  end

  // ****************************************
  // Averaging sequencer and divider
  // ****************************************
  mfac_pkg::mfac_avg_e avg_st_q;
  logic [24:0] tick_cnt_q;
  logic [15:0] wait_q, cnt_q, div_den_q;
  logic [31:0] sum_q, num_q;
  logic [16:0] rem_q;
  logic [5:0] div_left_q;
  wire tick = tick_cnt_q == 25'(TENTH_CYC - 1);
  wire avg_go = second_port_function == `MFAC_PORT_FN_AVG_HOLD && dig_in;
  wire in_band = moisture >= avg_floor_q && moisture <= avg_include_high;
  wire logic [16:0] rem_sh = {rem_q[15:0], num_q[31]};

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) tick_cnt_q <= 25'h0000000;
    else tick_cnt_q <= (tick || avg_st_q != mfac_pkg::AVG_WAIT) ? 25'h0000000 : tick_cnt_q + 25'h0000001;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      avg_st_q <= mfac_pkg::AVG_IDLE;
      wait_q <= 16'h0000;
      sum_q <= 32'h00000000;
      cnt_q <= 16'h0000;
    end else begin
      unique case (avg_st_q)
        mfac_pkg::AVG_IDLE, mfac_pkg::AVG_HOLD: if (avg_go) begin
          avg_st_q <= mfac_pkg::AVG_WAIT;
          wait_q <= 16'h0000;
          sum_q <= 32'h00000000;
          cnt_q <= 16'h0000;
        end
        mfac_pkg::AVG_WAIT: begin
          if (!avg_go) avg_st_q <= mfac_pkg::AVG_HOLD;
          else if (wait_q >= delay_tenths) avg_st_q <= mfac_pkg::AVG_ACC;
          else if (tick) wait_q <= wait_q + 16'h0001;
        end
        mfac_pkg::AVG_ACC: begin
          if (!avg_go) avg_st_q <= mfac_pkg::AVG_HOLD;
          else if (sample_valid && in_band && cnt_q != 16'hFFFF) begin
            sum_q <= sum_q + {16'h0000, moisture};
            cnt_q <= cnt_q + 16'h0001;
          end
        end
      endcase
    end
  end

  // Divider starts when accumulation ends with a nonzero count; the held average only changes on completion
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      div_left_q <= 6'h00;
      num_q <= 32'h00000000;
      rem_q <= 17'h00000;
      div_den_q <= 16'h0000;
      average_moisture <= 16'h0000;
    end else if (avg_st_q == mfac_pkg::AVG_ACC && !avg_go && cnt_q != 16'h0000) begin
      div_left_q <= 6'h20;
      num_q <= sum_q;
      rem_q <= 17'h00000;
      div_den_q <= cnt_q;
    end else if (div_left_q != 6'h00) begin
      div_left_q <= div_left_q - 6'h01;
      rem_q <= (rem_sh >= {1'b0, div_den_q}) ? rem_sh - {1'b0, div_den_q} : rem_sh;
      num_q <= {num_q[30:0], rem_sh >= {1'b0, div_den_q}};
      if (div_left_q == 6'h01) begin
        average_moisture <= num_q[30:15] != 16'h0000 ? 16'hFFFF
                            : {num_q[14:0], rem_sh >= {1'b0, div_den_q}};
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) averaging <= 1'b0;
    else averaging <= avg_st_q == mfac_pkg::AVG_ACC && avg_go;
  end

  // ****************************************
  // Second digital port output
  // ****************************************
  wire cal_out = ({1'b0, sel} + {1'b0, `MFAC_CAL_MARGIN} < {1'b0, cal_unscaled_low}) ||
                 ({1'b0, sel} > {1'b0, cal_unscaled_high} + {1'b0, `MFAC_CAL_MARGIN});

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) second_digital_port <= 1'b0;
    else if (second_port_function == `MFAC_PORT_FN_CAL_RANGE) second_digital_port <= cal_out;
    else if (second_port_function == `MFAC_PORT_FN_STABLE) second_digital_port <= stable;
    else second_digital_port <= 1'b0;
  end

  // ****************************************
  // Assertions
  // ****************************************
  a_bad_write_kept: assert property (@(posedge mclk) disable iff (!rstn)
    reg_wr && reg_addr == `MFAC_ADDR_DSP && reg_wdata > `MFAC_MAX_DSP |=> $stable(dsp_q) && reg_exc)
    else $error("illegal code stored");
  a_good_write_stored: assert property (@(posedge mclk) disable iff (!rstn)
    reg_wr && reg_addr == `MFAC_ADDR_WINDOW && reg_wdata <= `MFAC_MAX_WINDOW |=> window_q == $past(reg_wdata) && !reg_exc)
    else $error("legal write lost");
  a_floor_freezes: assert property (@(posedge mclk) disable iff (!rstn)
    sample_valid && sel < filt_floor_q |=> $stable(filtered_unscaled) && !filter_included)
    else $error("filter moved below floor");
  a_rise_limited: assert property (@(posedge mclk) disable iff (!rstn)
    sample_valid && include_now && rise_q != 16'h0000 |=> 17'(slew_out_q) <= 17'($past(slew_out_q)) + 17'($past(rise_step)))
    else $error("rise step too large");
  a_delay_waited: assert property (@(posedge mclk) disable iff (!rstn)
    avg_st_q == mfac_pkg::AVG_WAIT ##1 avg_st_q == mfac_pkg::AVG_ACC |-> $past(wait_q) >= $past(delay_tenths))
    else $error("accumulation started early");
  a_out_band_skip: assert property (@(posedge mclk) disable iff (!rstn)
    avg_st_q == mfac_pkg::AVG_ACC && sample_valid && !in_band |=> $stable(cnt_q))
    else $error("out of band sample counted");
  a_cal_range_out: assert property (@(posedge mclk) disable iff (!rstn)
    second_port_function == `MFAC_PORT_FN_CAL_RANGE |=> second_digital_port == $past(cal_out))
    else $error("cal range output wrong");
  a_hold_average: assert property (@(posedge mclk) disable iff (!rstn)
    div_left_q == 6'h00 && !(avg_st_q == mfac_pkg::AVG_ACC && !avg_go) |=> $stable(average_moisture))
    else $error("average changed while held");
  a_delay_decode: assert property (@(posedge mclk) disable iff (!rstn)
    avg_delay_q == 16'h0007 |-> delay_tenths == 16'h00C8)
    else $error("delay decode wrong");
  c_avg_done: cover property (@(posedge mclk) disable iff (!rstn) div_left_q == 6'h01);
  c_reject: cover property (@(posedge mclk) disable iff (!rstn) reg_exc);
  c_stable: cover property (@(posedge mclk) disable iff (!rstn) $rose(stable));

endmodule // mfac_top

// File: verif/mfac_host_model.sv
// Register host model that drives the holding-register port
`timescale 1ns/1ps
module mfac_host_model (
  input wire logic mclk,
  output logic [15:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_ack,
  input wire logic reg_exc
);
  initial begin
    reg_addr = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 16'h0000;
  end

  // ****************************************
  // One request, answer captured with the acknowledge
  // ****************************************
  task automatic access(input logic wr, input logic [15:0] addr, input logic [15:0] wdata,
                        output logic [15:0] rdata, output logic exc, output logic ok);
    ok = 1'b0;
    rdata = 16'h0000;
    exc = 1'b0;
    @(negedge mclk);
    reg_addr = addr;
    reg_wdata = wdata;
    reg_wr = wr;
    reg_rd = ~wr;
    @(negedge mclk);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    // Released lines show garbage, not the last value
    reg_addr = ~addr;
    reg_wdata = ~wdata;
    // The acknowledge stands for one cycle only, so look before waiting again
    for (int n = 0; n < 4 && !ok; n++) begin
      if (reg_ack === 1'b1) begin
        ok = 1'b1;
        rdata = reg_rdata;
        exc = reg_exc;
      end else begin
        @(negedge mclk);
      end
    end
  endtask
endmodule // mfac_host_model

// File: verif/mfac_bench.sv
// Self-checking testbench of the moisture filter config bank
`timescale 1ns/1ps
`include "mfac_defs.svh"
module moisture_filter_average_config_bench;
  localparam int unsigned TENTH = 10;
  logic mclk, rstn, reg_wr, reg_rd, reg_ack, reg_exc, dig_in, sample_valid;
  logic averaging, filter_included, stable, second_digital_port, ex, ok, exp_bit;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, unscaled_f, unscaled_v, unscaled_e, moisture;
  logic [15:0] avg_include_high, cal_unscaled_low, cal_unscaled_high, filtered_unscaled;
  logic [15:0] average_moisture, rd, v;
  logic [3:0] second_port_function;
  logic [2:0] alarm_mode;
  int failures, n_tests, seed, sum, cnt, k;
  int mdl[9];
  int maxv[9] = '{7, 99, 50, 51, 5, -1, 100, -1, 1000};
  int cal_f[6] = '{500, 969, 970, 1500, 2030, 2031};
  logic cal_e[6] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
  int mq[$] = '{50, 100, 300, 600, 500};

  mfac_top #(.TENTH_CYC(TENTH)) i_mfac_top (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack), .reg_exc(reg_exc),
    .second_port_function(second_port_function), .alarm_mode(alarm_mode), .dig_in(dig_in),
    .sample_valid(sample_valid),
    .unscaled_f(unscaled_f), .unscaled_v(unscaled_v), .unscaled_e(unscaled_e), .moisture(moisture),
    .avg_include_high(avg_include_high), .cal_unscaled_low(cal_unscaled_low),
    .cal_unscaled_high(cal_unscaled_high), .filtered_unscaled(filtered_unscaled),
    .average_moisture(average_moisture), .averaging(averaging), .filter_included(filter_included),
    .stable(stable), .second_digital_port(second_digital_port));

  mfac_host_model i_mfac_host_model (.mclk(mclk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack), .reg_exc(reg_exc));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic acc(input logic wr, input logic [15:0] addr, input logic [15:0] wdata);
    i_mfac_host_model.access(wr, addr, wdata, rd, ex, ok);
    chk("ack", {15'h0000, ok}, 16'h0001);
  endtask

  task automatic smp(input logic [15:0] f, input logic [15:0] m);
    @(negedge mclk);
    sample_valid = 1'b1;
    unscaled_f = f;
    moisture = m;
    unscaled_v = 16'($random(seed));
    unscaled_e = 16'($random(seed));
    @(negedge mclk);
    sample_valid = 1'b0;
    repeat (3) @(negedge mclk);
  endtask

  task automatic do_reset();
    rstn = 1'b0;
    repeat (4) @(negedge mclk);
    rstn = 1'b1;
    for (int i = 0; i < 9; i++) mdl[i] = 0;
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    #50000;
    failures++;
    give_verdict();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    seed = 63;
    {dig_in, sample_valid, unscaled_f, unscaled_v, unscaled_e, moisture} = '0;
    second_port_function = 4'h0;
    alarm_mode = 3'h0;
    avg_include_high = 16'h01F4;
    cal_unscaled_low = 16'h03E8;
    cal_unscaled_high = 16'h07D0;
    do_reset();
    for (int i = 0; i < 9; i++) begin
      acc(1'b0, 16'h9C5C + 16'(i), 16'h0000);
      chk("reset_value", rd, 16'(mdl[i]));
    end
    for (int i = 0; i < 9; i++) begin
      v = (maxv[i] < 0) ? 16'($random(seed)) : 16'($unsigned($random(seed)) % (maxv[i] + 1));
      acc(1'b1, 16'h9C5C + 16'(i), v);
      chk("legal_write", {15'h0000, ex}, 16'h0000);
      mdl[i] = v;
      if (maxv[i] >= 0) begin
        acc(1'b1, 16'h9C5C + 16'(i), 16'(maxv[i]));
        chk("top_code", {15'h0000, ex}, 16'h0000);
        mdl[i] = maxv[i];
        acc(1'b1, 16'h9C5C + 16'(i), 16'(maxv[i] + 1));
        chk("refused", {15'h0000, ex}, 16'h0001);
      end
      acc(1'b0, 16'h9C5C + 16'(i), 16'h0000);
      chk("readback", rd, 16'(mdl[i]));
    end
    acc(1'b0, 16'h9C65, 16'h0000);
    chk("unmapped_exc", {15'h0000, ex}, 16'h0001);
    chk("unmapped_data", rd, 16'h0000);
    do_reset();
    // Stability flag against the deviation limit, shown on the second port
    second_port_function = `MFAC_PORT_FN_STABLE;
    acc(1'b1, `MFAC_ADDR_DEV_LIMIT, 16'h0000);
    smp(16'h0050, 16'h0000);
    chk("stable_zero_limit", {15'h0000, stable}, 16'h0000);
    chk("stable_out_low", {15'h0000, second_digital_port}, 16'h0000);
    acc(1'b1, `MFAC_ADDR_DEV_LIMIT, 16'hFFFF);
    smp(16'h0050, 16'h0000);
    chk("stable_wide_limit", {15'h0000, stable}, 16'h0001);
    chk("stable_out_high", {15'h0000, second_digital_port}, 16'h0001);
    // Calibration range output
    second_port_function = `MFAC_PORT_FN_CAL_RANGE;
    for (int j = 0; j < 6; j++) begin
      smp(16'(cal_f[j]), 16'h0000);
      chk("cal_range_out", {15'h0000, second_digital_port}, {15'h0000, cal_e[j]});
    end
    // Alarm mode picks the random V or E reading for the range check
    for (int j = 0; j < 2; j++) begin
      alarm_mode = 3'(2 + j);
      smp(16'h05DC, 16'h0000);
      k = (j == 0) ? int'(unscaled_v) : int'(unscaled_e);
      exp_bit = k + int'(`MFAC_CAL_MARGIN) < int'(cal_unscaled_low) ||
                k > int'(cal_unscaled_high) + int'(`MFAC_CAL_MARGIN);
      chk("cal_range_mode", {15'h0000, second_digital_port}, {15'h0000, exp_bit});
    end
    alarm_mode = 3'h0;
    // Filter freeze below the inclusion floor
    second_port_function = 4'h0;
    acc(1'b1, `MFAC_ADDR_FILT_FLOOR, 16'h0064);
    repeat (3) smp(16'h07D0, 16'h0000);
    chk("filtered_pass", filtered_unscaled, 16'h07D0);
    chk("included", {15'h0000, filter_included}, 16'h0001);
    repeat (2) smp(16'h0032, 16'h0000);
    chk("filtered_frozen", filtered_unscaled, 16'h07D0);
    chk("excluded", {15'h0000, filter_included}, 16'h0000);
    // Slew limits: heavy rising step, then a custom falling step of 4 tenths per sample
    acc(1'b1, `MFAC_ADDR_RISE, 16'h0003);
    repeat (3) smp(16'h0834, 16'h0000);
    chk("rise_limited", filtered_unscaled, 16'h07D0 + `MFAC_SLEW_HEAVY);
    acc(1'b1, `MFAC_ADDR_FALL, 16'h0004);
    repeat (3) smp(16'h076C, 16'h0000);
    chk("fall_limited", filtered_unscaled, 16'h07EA);
    // Average with start delay and inclusion limits
    second_port_function = `MFAC_PORT_FN_AVG_HOLD;
    acc(1'b1, `MFAC_ADDR_AVG_DELAY, 16'h0001);
    acc(1'b1, `MFAC_ADDR_AVG_FLOOR, 16'h0064);
    dig_in = 1'b1;
    repeat (40) @(negedge mclk);
    chk("avg_waiting", {15'h0000, averaging}, 16'h0000);
    for (k = 0; k < 30 && averaging !== 1'b1; k++) @(negedge mclk);
    chk("avg_delay_ok", {15'h0000, (k >= 5 && k <= 18)}, 16'h0001);
    sum = 0;
    cnt = 0;
    foreach (mq[j]) begin
      smp(16'h07D0, 16'(mq[j]));
      if (mq[j] >= 100 && mq[j] <= 500) begin
        sum += mq[j];
        cnt++;
      end
    end
    dig_in = 1'b0;
    repeat (60) @(negedge mclk);
    chk("average", average_moisture, 16'(sum / cnt));
    chk("avg_stopped", {15'h0000, averaging}, 16'h0000);
    smp(16'h07D0, 16'h0190);
    chk("average_held", average_moisture, 16'(sum / cnt));
    give_verdict();
  end
endmodule // moisture_filter_average_config_bench
